// [shared/pcmr_defines.vh]
// constants for the clause 22 management register bank and its mdio slave
`ifndef PCMR_DEFINES_VH
`define PCMR_DEFINES_VH

// ==========================================================
// register addresses (5-bit management address)
`define PCMR_ADDR_PHY_CONTROL 5'h00
`define PCMR_ADDR_PHY_STATUS 5'h01
`define PCMR_ADDR_PHY_ID_HIGH 5'h02
`define PCMR_ADDR_PHY_ID_LOW 5'h03
`define PCMR_ADDR_IACC_CONTROL 5'h0d
`define PCMR_ADDR_IACC_DATA 5'h0e

// ==========================================================
// phy_control field positions
`define PCMR_CTL_SOFT_RESET 15
`define PCMR_CTL_PCS_LOOPBACK 14
`define PCMR_CTL_SPEED_LOW 13
`define PCMR_CTL_AUTONEG 12
`define PCMR_CTL_POWERDOWN 11
`define PCMR_CTL_ISOLATE 10
`define PCMR_CTL_DUPLEX 8
`define PCMR_CTL_COLL_TEST 7
`define PCMR_CTL_SPEED_HIGH 6
`define PCMR_CTL_ONE_WAY 5
`define PCMR_CTL_RESET 16'h1100

// ==========================================================
// phy_status fields and fixed value
`define PCMR_STAT_FIXED 16'h1009
`define PCMR_STAT_AN_COMPLETE 5
`define PCMR_STAT_LINK 2

// ==========================================================
// indirect access control fields and reset values
`define PCMR_IACC_FUNC_HIGH 15
`define PCMR_IACC_FUNC_LOW 14
`define PCMR_IACC_DEVAD_HIGH 4
`define PCMR_IACC_RESET 16'h0000

// ==========================================================
// mdio frame constants
`define PCMR_OP_WRITE 2'b01
`define PCMR_OP_READ 2'b10
`define PCMR_PREAMBLE_BITS 6'd32
`define PCMR_HDR_LAST 5'd12
`define PCMR_DATA_LAST 5'd15

// ==========================================================
// timing
`define PCMR_CLK_MHZ 20
`define PCMR_SOFT_RESET_NS 1000
`define PCMR_SOFT_RESET_CYC ((`PCMR_SOFT_RESET_NS * `PCMR_CLK_MHZ + 999) / 1000)
`define PCMR_STRAP_CAPTURE 3'd6

`endif

// [hdl/pcmr_sync.v]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module pcmr_sync
#(
   parameter WIDTH = 1
)
(
   input wire CLK,
   input wire RST_N,
   input wire [WIDTH-1:0] D,
   output reg [WIDTH-1:0] Q
);

   // ==========================================================
   // stages
   reg [WIDTH-1:0] stage1; // metastable catcher, read only by stage2
   reg [WIDTH-1:0] stage2; // second stage
   reg [WIDTH-1:0] stage3; // third stage

   // ==========================================================
   // shift chain, output follows once stages two and three agree
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         Q <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1 <= D;
         stage2 <= stage1;
         stage3 <= stage2;
         // per bit: take the new level only when agreed
         Q <= (stage2 & ~(stage2 ^ stage3)) | (Q & (stage2 ^ stage3));
      end
   end

endmodule

// [hdl/pcmr_regs.v]
// clause 22 management register bank with its mdio serial slave
//
// Contract
// RULE_01 - control bit 15 self-clearing soft reset, mirrored
// RULE_02 - control bit 14 enables pcs loopback
// RULE_03 - control bit 12 read-only, reads one
// RULE_04 - bit 11 powers down; mdio keeps working
// RULE_05 - power-down reset value comes from strap
// RULE_06 - control bit 10 isolates, resets zero
// RULE_07 - duplex bit 8 always reads one
// RULE_08 - collision test bit 7 reads zero
// RULE_09 - speed select bits read 00
// RULE_10 - one-way enable bit 5 reads zero
// RULE_11 - control register resets to 0x1100
// RULE_12 - identifier registers 0x2/0x3 fixed read-only
// RULE_13 - indirect control top bits select function
// RULE_14 - read-only, reserved bits unchanged, read zero
`timescale 1ns/1ps
`include "pcmr_defines.vh"

module pcmr_regs
#(
   parameter [15:0] ID_HIGH = 16'h5a5a, // arbitrary identifier value
   parameter [5:0] ID_OUI_LOW = 6'h15, // arbitrary identifier value
   parameter [3:0] ID_REVISION = 4'h3, // arbitrary identifier value
   parameter [15:0] SOFT_RESET_CYCLES = `PCMR_SOFT_RESET_CYC
)
(
   input wire CLK,
   input wire RST_N,
   input wire MDC,
   input wire MDIO_IN,
   output reg MDIO_OUT,
   output reg MDIO_OE_N,
   input wire [4:0] PHY_ADDR_STRAP,
   input wire [5:0] MODEL_STRAP,
   input wire POWERDOWN_STRAP,
   input wire LINK_UP,
   input wire AN_COMPLETE,
   output reg SOFT_RESET,
   output reg PCS_LOOPBACK,
   output reg POWER_DOWN,
   output reg ISOLATE,
   output reg [1:0] INDIRECT_FUNCTION,
   output reg [4:0] INDIRECT_DEVAD,
   output reg [15:0] INDIRECT_DATA,
   output reg INDIRECT_WRITE,
   output reg INDIRECT_READ
);

   // ==========================================================
   // frame states, one-hot
   localparam [4:0] S_PRE = 5'h01; // counting preamble ones
   localparam [4:0] S_HDR = 5'h02; // start, opcode and addresses
   localparam [4:0] S_TA = 5'h04; // turnaround
   localparam [4:0] S_RD = 5'h08; // shifting data out
   localparam [4:0] S_WR = 5'h10; // shifting data in

   // ==========================================================
   // declarations
   wire [13:0] sync_q; // filtered pins
   wire mdc_lvl; // filtered mdc
   wire mdio_lvl; // filtered mdio input
   reg mdc_prev; // mdc one cycle ago
   wire mdc_rise; // mdc rising edge seen
   reg [2:0] start_cnt; // cycles since reset release
   reg [4:0] phy_addr; // captured address strap
   reg [5:0] model_num; // captured model strap
   reg pd_strap; // captured power-down strap
   reg [4:0] state; // frame state
   reg [5:0] pre_cnt; // preamble ones seen
   reg [4:0] bit_cnt; // bit within field
   reg [15:0] shift; // serial shift register
   reg is_read; // frame is a read
   reg [4:0] reg_addr; // register addressed
   reg wr_stb; // write strobe to the bank
   reg [15:0] wr_data; // data for the bank
   reg rd_stb; // read strobe, for read side effects
   reg link_latch; // latched-low link status
   reg [15:0] rst_cnt; // soft reset cycles remaining
   wire [12:0] hdr; // complete header with the current bit

   // ==========================================================
   // pin synchroniser: mdc, mdio and straps
   pcmr_sync #(.WIDTH(14)) u_sync
   (
      .CLK(CLK),
      .RST_N(RST_N),
      .D({POWERDOWN_STRAP, MODEL_STRAP, PHY_ADDR_STRAP, MDIO_IN, MDC}),
      .Q(sync_q)
   );

   assign mdc_lvl = sync_q[0];
   assign mdio_lvl = sync_q[1];
   assign mdc_rise = mdc_lvl & ~mdc_prev;
   assign hdr = {shift[11:0], mdio_lvl};

   // ==========================================================
   // read value of one register
   function [15:0] rd_value;
      input [4:0] addr;
      begin
         rd_value = 16'h0000; // unmapped and reserved read zero RULE_14
         case (addr)
            `PCMR_ADDR_PHY_CONTROL:
            begin
               rd_value[`PCMR_CTL_SOFT_RESET] = SOFT_RESET; // RULE_01
               rd_value[`PCMR_CTL_PCS_LOOPBACK] = PCS_LOOPBACK; // RULE_02
               rd_value[`PCMR_CTL_SPEED_LOW] = 1'b0; // RULE_09
               rd_value[`PCMR_CTL_AUTONEG] = 1'b1; // RULE_03
               rd_value[`PCMR_CTL_POWERDOWN] = POWER_DOWN; // RULE_04
               rd_value[`PCMR_CTL_ISOLATE] = ISOLATE; // RULE_06
               rd_value[`PCMR_CTL_DUPLEX] = 1'b1; // RULE_07
               rd_value[`PCMR_CTL_COLL_TEST] = 1'b0; // RULE_08
               rd_value[`PCMR_CTL_SPEED_HIGH] = 1'b0; // RULE_09
               rd_value[`PCMR_CTL_ONE_WAY] = 1'b0; // RULE_10
            end
            `PCMR_ADDR_PHY_STATUS:
            begin
               rd_value = `PCMR_STAT_FIXED;
               rd_value[`PCMR_STAT_AN_COMPLETE] = AN_COMPLETE;
               rd_value[`PCMR_STAT_LINK] = link_latch;
            end
            `PCMR_ADDR_PHY_ID_HIGH:
               rd_value = ID_HIGH; // RULE_12
            `PCMR_ADDR_PHY_ID_LOW:
               rd_value = {ID_OUI_LOW, model_num, ID_REVISION}; // RULE_12
            `PCMR_ADDR_IACC_CONTROL:
               rd_value = {INDIRECT_FUNCTION, 9'h000, INDIRECT_DEVAD}; // RULE_13
            `PCMR_ADDR_IACC_DATA:
               rd_value = INDIRECT_DATA;
            default:
               rd_value = 16'h0000;
         endcase
      end
   endfunction

   // ==========================================================
   // strap capture a few cycles after reset release
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         start_cnt <= 3'h0;
         phy_addr <= 5'h00;
         model_num <= 6'h00;
         pd_strap <= 1'b0;
      end
      else
      begin
         // count until the synchroniser has settled
         if (start_cnt != `PCMR_STRAP_CAPTURE)
         begin
            start_cnt <= start_cnt + 3'h1;
         end
         // capture once, when the filtered straps are valid
         if (start_cnt == `PCMR_STRAP_CAPTURE - 3'h1)
         begin
            phy_addr <= sync_q[6:2];
            model_num <= sync_q[12:7];
            pd_strap <= sync_q[13]; // RULE_05
         end
      end
   end

   // ==========================================================
   // mdio frame engine, advances on each mdc rising edge
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mdc_prev <= 1'b0;
         state <= S_PRE;
         pre_cnt <= 6'h00;
         bit_cnt <= 5'h00;
         shift <= 16'h0000;
         is_read <= 1'b0;
         reg_addr <= 5'h00;
         wr_stb <= 1'b0;
         wr_data <= 16'h0000;
         rd_stb <= 1'b0;
         MDIO_OUT <= 1'b1;
         MDIO_OE_N <= 1'b1;
      end
      else
      begin
         mdc_prev <= mdc_lvl;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (mdc_rise)
         begin
            case (state)
               S_PRE:
               begin
                  // ones fill the preamble, a zero after a full one starts
                  if (mdio_lvl)
                  begin
                     if (pre_cnt != `PCMR_PREAMBLE_BITS)
                     begin
                        pre_cnt <= pre_cnt + 6'h01;
                     end
                  end
                  else if (pre_cnt == `PCMR_PREAMBLE_BITS)
                  begin
                     state <= S_HDR;
                     bit_cnt <= 5'h00;
                     shift <= 16'h0000;
                  end
                  else
                  begin
                     pre_cnt <= 6'h00;
                  end
               end
               S_HDR:
               begin
                  shift <= {shift[14:0], mdio_lvl};
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == `PCMR_HDR_LAST)
                  begin
                     pre_cnt <= 6'h00;
                     bit_cnt <= 5'h00;
                     // accept only a valid start, opcode and our address
                     if (hdr[12] && (hdr[9:5] == phy_addr) &&
                         ((hdr[11:10] == `PCMR_OP_READ) ||
                          (hdr[11:10] == `PCMR_OP_WRITE)))
                     begin
                        state <= S_TA;
                        reg_addr <= hdr[4:0];
                        is_read <= (hdr[11:10] == `PCMR_OP_READ);
                        if (hdr[11:10] == `PCMR_OP_READ)
                        begin
                           shift <= rd_value(hdr[4:0]);
                           rd_stb <= 1'b1;
                        end
                     end
                     else
                     begin
                        state <= S_PRE;
                     end
                  end
               end
               S_TA:
               begin
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == 5'h00)
                  begin
                     // second turnaround bit driven low on reads
                     if (is_read)
                     begin
                        MDIO_OUT <= 1'b0;
                        MDIO_OE_N <= 1'b0;
                     end
                  end
                  else
                  begin
                     bit_cnt <= 5'h00;
                     if (is_read)
                     begin
                        state <= S_RD;
                        MDIO_OUT <= shift[15];
                        shift <= {shift[14:0], 1'b0};
                     end
                     else
                     begin
                        state <= S_WR;
                     end
                  end
               end
               S_RD:
               begin
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == `PCMR_DATA_LAST)
                  begin
                     // last bit sampled by the host, release the line
                     MDIO_OUT <= 1'b1;
                     MDIO_OE_N <= 1'b1;
                     state <= S_PRE;
                  end
                  else
                  begin
                     MDIO_OUT <= shift[15];
                     shift <= {shift[14:0], 1'b0};
                  end
               end
               S_WR:
               begin
                  shift <= {shift[14:0], mdio_lvl};
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == `PCMR_DATA_LAST)
                  begin
                     wr_stb <= 1'b1;
                     wr_data <= {shift[14:0], mdio_lvl};
                     state <= S_PRE;
                  end
               end
               default:
               begin
                  state <= S_PRE;
                  pre_cnt <= 6'h00;
                  MDIO_OE_N <= 1'b1;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // register bank; mdio stays live in every control mode
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         SOFT_RESET <= 1'b0; // RULE_11
         PCS_LOOPBACK <= 1'b0; // RULE_11
         POWER_DOWN <= 1'b0;
         ISOLATE <= 1'b0; // RULE_06
         INDIRECT_FUNCTION <= 2'b00; // function field of the all-zero reset value
         INDIRECT_DEVAD <= 5'h00;
         INDIRECT_DATA <= 16'h0000;
         INDIRECT_WRITE <= 1'b0;
         INDIRECT_READ <= 1'b0;
         rst_cnt <= 16'h0000;
         link_latch <= 1'b0;
      end
      else
      begin
         INDIRECT_WRITE <= 1'b0;
         INDIRECT_READ <= 1'b0;
         // latched-low link: a read reloads, a failure wins
         if (rd_stb && (reg_addr == `PCMR_ADDR_PHY_STATUS))
         begin
            link_latch <= LINK_UP;
         end
         else if (!LINK_UP)
         begin
            link_latch <= 1'b0;
         end
         // strap value becomes the power-down default
         if (start_cnt == `PCMR_STRAP_CAPTURE - 3'h1)
         begin
            POWER_DOWN <= sync_q[13]; // RULE_05
         end
         if (rd_stb && (reg_addr == `PCMR_ADDR_IACC_DATA))
         begin
            INDIRECT_READ <= 1'b1; // RULE_13
         end
         if (SOFT_RESET)
         begin
            // soft reset running; at its end the bank returns to defaults
            if (rst_cnt <= 16'h0001)
            begin
               SOFT_RESET <= 1'b0; // RULE_01
               PCS_LOOPBACK <= 1'b0;
               POWER_DOWN <= pd_strap; // RULE_05
               ISOLATE <= 1'b0;
               INDIRECT_FUNCTION <= 2'b00;
               INDIRECT_DEVAD <= 5'h00;
               INDIRECT_DATA <= 16'h0000;
               rst_cnt <= 16'h0000;
            end
            else
            begin
               rst_cnt <= rst_cnt - 16'h0001;
            end
         end
         else if (wr_stb)
         begin
            case (reg_addr)
               `PCMR_ADDR_PHY_CONTROL:
               begin
                  // only writable bits change; fixed bits ignore writes RULE_14
                  if (wr_data[`PCMR_CTL_SOFT_RESET])
                  begin
                     SOFT_RESET <= 1'b1; // RULE_01
                     rst_cnt <= SOFT_RESET_CYCLES;
                  end
                  PCS_LOOPBACK <= wr_data[`PCMR_CTL_PCS_LOOPBACK]; // RULE_02
                  POWER_DOWN <= wr_data[`PCMR_CTL_POWERDOWN]; // RULE_04
                  ISOLATE <= wr_data[`PCMR_CTL_ISOLATE]; // RULE_06
               end
               `PCMR_ADDR_IACC_CONTROL:
               begin
                  INDIRECT_FUNCTION <= wr_data[`PCMR_IACC_FUNC_HIGH:`PCMR_IACC_FUNC_LOW]; // RULE_13
                  INDIRECT_DEVAD <= wr_data[`PCMR_IACC_DEVAD_HIGH:0];
               end
               `PCMR_ADDR_IACC_DATA:
               begin
                  INDIRECT_DATA <= wr_data;
                  INDIRECT_WRITE <= 1'b1; // RULE_13
               end
               default:
               begin
                  // read-only and unmapped addresses ignore writes RULE_14
                  INDIRECT_WRITE <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// [testbench/pcmr_regs_assertions.sv]
// concurrent checks on the ports of the clause 22 register bank
`timescale 1ns/1ps

module pcmr_regs_assertions
#(
   parameter [15:0] SOFT_RESET_CYCLES = 16'h0014
)
(
   input wire CLK,
   input wire RST_N,
   input wire MDC,
   input wire MDIO_IN,
   input wire MDIO_OUT,
   input wire MDIO_OE_N,
   input wire [4:0] PHY_ADDR_STRAP,
   input wire [5:0] MODEL_STRAP,
   input wire POWERDOWN_STRAP,
   input wire LINK_UP,
   input wire AN_COMPLETE,
   input wire SOFT_RESET,
   input wire PCS_LOOPBACK,
   input wire POWER_DOWN,
   input wire ISOLATE,
   input wire [1:0] INDIRECT_FUNCTION,
   input wire [4:0] INDIRECT_DEVAD,
   input wire [15:0] INDIRECT_DATA,
   input wire INDIRECT_WRITE,
   input wire INDIRECT_READ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // ==========================================================
   // helper: length of the current soft reset pulse
   reg [15:0] hi_cnt; // cycles seen high so far
   always @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         hi_cnt <= 16'h0000;
      else if (SOFT_RESET)
         hi_cnt <= hi_cnt + 16'h0001;
      else
         hi_cnt <= 16'h0000;
   end

   // ==========================================================
   // assertions
   chk_soft_length: assert property ($fell(SOFT_RESET) |->
      (hi_cnt >= SOFT_RESET_CYCLES) && (hi_cnt <= SOFT_RESET_CYCLES + 16'h0001))
      else $error("soft reset pulse has the wrong length");
   chk_soft_defaults: assert property ($fell(SOFT_RESET) |-> ##[0:2]
      (!PCS_LOOPBACK && !ISOLATE && INDIRECT_DATA == 16'h0000 && INDIRECT_FUNCTION == 2'b00
      && INDIRECT_DEVAD == 5'h00 && POWER_DOWN == POWERDOWN_STRAP))
      else $error("soft reset did not restore defaults");
   chk_strap_powerdown: assert property ($rose(RST_N) |-> ##10
      (POWER_DOWN == POWERDOWN_STRAP))
      else $error("power-down does not follow its strap after reset");
   chk_ctl_read_quiet: assert property (($changed(PCS_LOOPBACK) || $changed(ISOLATE))
      |-> MDIO_OE_N)
      else $error("control outputs changed during a read answer");
   chk_ta_drives_zero: assert property ($fell(MDIO_OE_N) |-> !MDIO_OUT)
      else $error("turnaround not driven low");
   chk_drive_mdc_high: assert property (($changed(MDIO_OUT) || $changed(MDIO_OE_N)) |-> MDC)
      else $error("mdio output moved while mdc low");
   chk_rd_then_drive: assert property ($rose(INDIRECT_READ) |->
      MDIO_OE_N ##[1:40] !MDIO_OE_N)
      else $error("indirect read strobe not followed by an answer");
   chk_wr_pulse_single: assert property (INDIRECT_WRITE |=> !INDIRECT_WRITE)
      else $error("indirect write strobe longer than one cycle");
   chk_rd_pulse_single: assert property (INDIRECT_READ |=> !INDIRECT_READ)
      else $error("indirect read strobe longer than one cycle");

   // ==========================================================
   // main scenarios seen
   cov_soft_reset: cover property ($rose(SOFT_RESET));
   cov_ind_write: cover property (INDIRECT_WRITE);
   cov_read_answer: cover property ($fell(MDIO_OE_N));
endmodule

bind pcmr_regs pcmr_regs_assertions #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_pcmr_chk (
   .CLK(CLK), .RST_N(RST_N), .MDC(MDC), .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT),
   .MDIO_OE_N(MDIO_OE_N), .PHY_ADDR_STRAP(PHY_ADDR_STRAP), .MODEL_STRAP(MODEL_STRAP),
   .POWERDOWN_STRAP(POWERDOWN_STRAP), .LINK_UP(LINK_UP), .AN_COMPLETE(AN_COMPLETE),
   .SOFT_RESET(SOFT_RESET), .PCS_LOOPBACK(PCS_LOOPBACK), .POWER_DOWN(POWER_DOWN),
   .ISOLATE(ISOLATE), .INDIRECT_FUNCTION(INDIRECT_FUNCTION), .INDIRECT_DEVAD(INDIRECT_DEVAD),
   .INDIRECT_DATA(INDIRECT_DATA), .INDIRECT_WRITE(INDIRECT_WRITE),
   .INDIRECT_READ(INDIRECT_READ));

// [testbench/pcmr_host_model.sv]
// station management host model driving clause 22 mdio frames
`timescale 1ns/1ps

module pcmr_host_model
(
   input wire CLK,
   input wire MDIO_OUT,
   input wire MDIO_OE_N,
   output reg MDC,
   output wire MDIO
);
   reg host_oe; // host drives the line
   reg host_bit; // value the host drives

   // ==========================================================
   // resolved line: device, else host, else pull-up
   assign MDIO = !MDIO_OE_N ? MDIO_OUT : (host_oe ? host_bit : 1'b1);

   initial
   begin
      MDC = 1'b0;
      host_oe = 1'b1;
      host_bit = 1'b1;
   end

   // one bit slot: data set while mdc low, sampled just before the rise
   task automatic mdc_bit(input logic b, input logic drv, output logic s);
      host_oe = drv;
      host_bit = b;
      repeat (8) @(negedge CLK);
      s = MDIO;
      MDC = 1'b1;
      repeat (8) @(negedge CLK);
      MDC = 1'b0;
   endtask

   // whole frame with its own preamble; line released over ta and data on reads
   task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
      logic [31:0] frame;
      logic s;
      integer i;
      frame = {2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
      q = 16'h0000;
      for (i = 0; i < 32; i++)
         mdc_bit(1'b1, 1'b1, s);
      for (i = 31; i >= 0; i--)
      begin
         mdc_bit(frame[i], !rd || i > 17, s);
         if (i < 16)
            q[i] = s;
      end
      host_oe = 1'b1;
      host_bit = 1'b1;
   endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the clause 22 register bank
`timescale 1ns/1ps

module tb_top;
   localparam [4:0] PHY = 5'h05; // strapped phy address
   localparam [5:0] MODEL = 6'h2a; // strapped model number
   localparam [15:0] IDH = 16'h1234; // arbitrary identifier value
   localparam [5:0] OUIL = 6'h0c; // arbitrary identifier value
   localparam [3:0] REV = 4'h7; // arbitrary identifier value
   reg clk, rst_n, pd_strap, link_up, an_done;
   wire mdc, mdio, mdio_out, mdio_oe_n, soft_reset, pcs_loopback, power_down, isolate;
   wire ind_wr, ind_rd;
   wire [1:0] ind_func;
   wire [4:0] ind_devad;
   wire [15:0] ind_data;
   integer n_fail, n_compared, k;
   integer n_iw = 0; // indirect write strobes seen
   integer n_ir = 0; // indirect read strobes seen

   // count the indirect strobes that the design drives
   always @(posedge clk)
   begin
      if (ind_wr)
         n_iw <= n_iw + 1;
      if (ind_rd)
         n_ir <= n_ir + 1;
   end

   // ==========================================================
   // design and host
   pcmr_regs #(.ID_HIGH(IDH), .ID_OUI_LOW(OUIL), .ID_REVISION(REV)) u_pcmr_regs (
      .CLK(clk), .RST_N(rst_n), .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_out),
      .MDIO_OE_N(mdio_oe_n), .PHY_ADDR_STRAP(PHY), .MODEL_STRAP(MODEL),
      .POWERDOWN_STRAP(pd_strap), .LINK_UP(link_up), .AN_COMPLETE(an_done),
      .SOFT_RESET(soft_reset), .PCS_LOOPBACK(pcs_loopback), .POWER_DOWN(power_down),
      .ISOLATE(isolate), .INDIRECT_FUNCTION(ind_func), .INDIRECT_DEVAD(ind_devad),
      .INDIRECT_DATA(ind_data), .INDIRECT_WRITE(ind_wr), .INDIRECT_READ(ind_rd));
   pcmr_host_model u_pcmr_host_model (.CLK(clk), .MDIO_OUT(mdio_out),
      .MDIO_OE_N(mdio_oe_n), .MDC(mdc), .MDIO(mdio));

   // 20 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========================================================
   // tasks
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      u_pcmr_host_model.xfer(1'b0, PHY, a, d, q);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      u_pcmr_host_model.xfer(1'b1, PHY, a, 16'h0000, q);
      cmp16(q, e);
   endtask

   // reset with a given power-down strap, then let the straps be captured
   task automatic do_reset(input logic strap);
      @(negedge clk);
      rst_n = 1'b0;
      pd_strap = strap;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (10) @(negedge clk);
   endtask

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // watchdog well beyond the expected run of about 1.8 ms
   initial
   begin
      #4500000;
      n_fail++;
      final_report;
   end

   // ==========================================================
   // test sequence
   initial
   begin
      rst_n = 1'b0;
      pd_strap = 1'b0;
      link_up = 1'b1;
      an_done = 1'b0;
      n_fail = 0;
      n_compared = 0;
      do_reset(1'b0);
      // reset values of every register
      rd_chk(5'h00, 16'h1100);
      rd_chk(5'h01, 16'h1009);
      rd_chk(5'h02, IDH);
      rd_chk(5'h03, {OUIL, MODEL, REV});
      rd_chk(5'h0d, 16'h0000);
      rd_chk(5'h0e, 16'h0000);
      $display("test reset_values done");
      // all writable bits except soft reset, and all fixed bits, of control at once
      reg_wr(5'h00, 16'h7fff);
      rd_chk(5'h00, 16'h5d00);
      cmp16({13'h0, pcs_loopback, power_down, isolate}, 16'h0007);
      // registers stay live while powered down
      reg_wr(5'h0e, 16'ha5c3);
      rd_chk(5'h0e, 16'ha5c3);
      cmp16(ind_data, 16'ha5c3);
      // one write strobe so far, two data reads so far
      cmp16({n_iw[7:0], n_ir[7:0]}, 16'h0102);
      reg_wr(5'h00, 16'h0000);
      rd_chk(5'h00, 16'h1100);
      cmp16({13'h0, pcs_loopback, power_down, isolate}, 16'h0000);
      $display("test control_bits done");
      // every indirect function code, reserved bits read zero
      for (k = 0; k < 4; k++)
      begin
         reg_wr(5'h0d, {k[1:0], 14'h3fff});
         rd_chk(5'h0d, {k[1:0], 9'h000, 5'h1f});
         cmp16({9'h000, ind_func, ind_devad}, {9'h000, k[1:0], 5'h1f});
      end
      // read-only places ignore writes, unmapped reads zero
      reg_wr(5'h02, 16'h0000);
      reg_wr(5'h03, 16'hffff);
      reg_wr(5'h01, 16'h0000);
      rd_chk(5'h02, IDH);
      rd_chk(5'h03, {OUIL, MODEL, REV});
      rd_chk(5'h07, 16'h0000);
      $display("test indirect_and_readonly done");
      // status: latched-low link and autoneg complete
      an_done = 1'b1;
      rd_chk(5'h01, 16'h102d);
      link_up = 1'b0;
      repeat (3) @(negedge clk);
      link_up = 1'b1;
      rd_chk(5'h01, 16'h1029);
      rd_chk(5'h01, 16'h102d);
      $display("test status done");
      // soft reset pulse clears itself and restores defaults
      reg_wr(5'h00, 16'h4400);
      // reset together with loopback, power-down and isolate set
      reg_wr(5'h00, 16'hcc00);
      for (k = 0; k < 40 && soft_reset !== 1'b1; k++)
         @(negedge clk);
      cmp16({15'h0, soft_reset}, 16'h0001);
      for (k = 0; k < 60 && soft_reset !== 1'b0; k++)
         @(negedge clk);
      cmp16({15'h0, soft_reset}, 16'h0000);
      cmp16({13'h0, pcs_loopback, power_down, isolate}, 16'h0000);
      rd_chk(5'h00, 16'h1100);
      rd_chk(5'h0d, 16'h0000);
      rd_chk(5'h0e, 16'h0000);
      $display("test soft_reset done");
      // power-down default taken from its strap
      do_reset(1'b1);
      rd_chk(5'h00, 16'h1900);
      cmp16({15'h0, power_down}, 16'h0001);
      $display("test powerdown_strap done");
      final_report;
   end
endmodule
